/* include/bcs_pkg.sv */
// Purpose: shared constants and types of the buffer channel scanner
// Assumes: 250 MHz system clock, six buffer channels
// Notes:   channel index 0 is buffer channel 1, index 5 is channel 6

package bcs_pkg;

    // ------------------------------------------------------------
    // channel set and scan order
    // ------------------------------------------------------------
    localparam int CHAN_N = 6;
    typedef logic [2:0] bcs_chan_t;
    typedef logic [CHAN_N-1:0] bcs_vec_t;
    localparam bcs_chan_t CHAN_LAST = 3'h5;
    localparam bcs_chan_t POS_FIRST = 3'h0;
    // channels 1-3-2-6-4-5 as zero based indices
    localparam bcs_chan_t SCAN_ORDER [CHAN_N] = '{3'h0, 3'h2, 3'h1, 3'h5, 3'h3, 3'h4};

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 4;
    // single channel word rate with one program access between words, tenths of KC
    localparam int RATE_1CH_WORST_DKC = 685;
    // a program slot and a buffer slot between two words of that channel
    localparam int SLOTS_PER_WORST_WORD = 2;
    // longest storage slot that still reaches that rate, rounded down
    localparam int SLOT_NS = 10000000 / (RATE_1CH_WORST_DKC * SLOTS_PER_WORST_WORD);
    localparam int SLOT_CYCLES_MAX = SLOT_NS / CLK_NS;
    // one scan step per channel fits exactly in a slot
    localparam int SCAN_CYCLES = SLOT_CYCLES_MAX / CHAN_N;
    localparam int SLOT_CYCLES = SCAN_CYCLES * CHAN_N;

    // ------------------------------------------------------------
    // scanner states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BCS_ST_SCAN = 2'h1,
        BCS_ST_HALT = 2'h2
    } bcs_state_t;

endpackage

/* include/bcs_req_if.sv */
// Purpose: carries synchronised equipment ready levels inside the scanner
// Assumes: one clock domain
// Notes:   driven by the pin synchroniser, read by the scanner core

`timescale 1ns/100ps
`default_nettype none

interface bcs_req_if;
    logic [bcs_pkg::CHAN_N-1:0] ready; // per channel ready, clean level
    modport src (output ready);
    modport dst (input ready);
endinterface

`default_nettype wire

/* rtl/bcs_tick_div.sv */
// Purpose: divider that yields a one-cycle enable every PERIOD clocks
// Assumes: PERIOD of two or more
// Notes:   first pulse comes PERIOD cycles after reset release

`timescale 1ns/100ps
`default_nettype none

module bcs_tick_div #(
    parameter int PERIOD = bcs_pkg::SCAN_CYCLES
) (
    input wire logic clock_i,   // system clock
    input wire logic sys_rst_i, // async reset, active high
    output logic tick_o         // one-cycle enable pulse
);
    import bcs_pkg::*;

    localparam int W = $clog2(PERIOD);
    localparam logic [W-1:0] CNT_LAST = W'(PERIOD - 1);
    localparam logic [W-1:0] CNT_STEP = W'(1);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    // count up through the period and flag its last cycle
    always_comb begin
        tick_nxt = (cnt_r == CNT_LAST);
        cnt_nxt = tick_nxt ? '0 : cnt_r + CNT_STEP;
    end

    // registers only
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_o = tick_r;

endmodule

`default_nettype wire

/* rtl/bcs_pin_sync.sv */
// Purpose: three-stage synchroniser for equipment ready pins
// Assumes: pins are asynchronous levels
// Notes:   a change is taken once the second and third stage agree

`timescale 1ns/100ps
`default_nettype none

module bcs_pin_sync (
    input wire logic clock_i,                 // system clock
    input wire logic sys_rst_i,               // async reset, active high
    input wire logic [bcs_pkg::CHAN_N-1:0] pin_i, // raw ready pins
    bcs_req_if.src req                        // clean ready levels
);
    import bcs_pkg::*;

    bcs_vec_t s1_r;
    bcs_vec_t s2_r;
    bcs_vec_t s3_r;
    bcs_vec_t out_r;
    bcs_vec_t out_nxt;
    bcs_vec_t agree_w;

    // keep the old level while the late stages disagree
    always_comb begin
        agree_w = ~(s2_r ^ s3_r);
        out_nxt = (agree_w & s3_r) | (~agree_w & out_r);
    end

    // stage one feeds stage two only
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            out_r <= '0;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end

    assign req.ready = out_r;

endmodule

`default_nettype wire

/* rtl/bcs_scanner.sv */
// Purpose: buffer control scanner granting storage words to six channels
// Assumes: armed and program request come from logic on clock_i
// Notes:   one buffer word or one program access per storage slot

`timescale 1ns/100ps
`default_nettype none

module bcs_scanner (
    input wire logic clock_i,                          // system clock 250 MHz
    input wire logic sys_rst_i,                        // async reset, active high
    input wire logic [bcs_pkg::CHAN_N-1:0] chan_armed_i, // buffer started by program
    input wire logic [bcs_pkg::CHAN_N-1:0] chan_ready_i, // equipment ready pins
    input wire logic prog_req_i,                       // program wants storage
    output logic [bcs_pkg::CHAN_N-1:0] buf_grant_o,    // one word to this channel
    output bcs_pkg::bcs_chan_t buf_chan_o,             // channel of last word
    output logic prog_grant_o,                         // slot given to program
    output logic slot_o,                               // storage slot boundary
    output bcs_pkg::bcs_chan_t scan_chan_o,            // channel under the scanner
    output logic halted_o                              // scanner halted on request
);
    import bcs_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // one-hot select line of a channel index
    function automatic bcs_vec_t chan_onehot(input bcs_chan_t c);
        chan_onehot = bcs_vec_t'(1) << c;
    endfunction

    localparam bcs_chan_t POS_STEP = 3'h1;

    // ------------------------------------------------------------
    // input side
    // ------------------------------------------------------------
    bcs_req_if rdy_if ();

    bcs_pin_sync u_sync (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(chan_ready_i),
        .req(rdy_if)
    );

    logic scan_tick_w;

    bcs_tick_div #(
        .PERIOD(SCAN_CYCLES)
    ) u_div (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .tick_o(scan_tick_w)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    bcs_state_t state_r;
    bcs_state_t state_nxt;
    bcs_chan_t pos_r;
    bcs_chan_t pos_nxt;
    bcs_chan_t slot_cnt_r;
    bcs_chan_t slot_cnt_nxt;
    logic slot_tick_r;
    logic slot_tick_nxt;
    bcs_chan_t last_chan_r;
    bcs_chan_t last_chan_nxt;
    logic last_valid_r;
    logic last_valid_nxt;
    bcs_vec_t buf_grant_r;
    bcs_vec_t buf_grant_nxt;
    bcs_chan_t buf_chan_r;
    bcs_chan_t buf_chan_nxt;
    logic prog_grant_r;
    logic prog_grant_nxt;
    bcs_chan_t scan_chan_r;

    bcs_vec_t req_w;
    bcs_chan_t cur_chan_w;
    logic cur_req_w;
    bcs_chan_t pos_inc_w;
    logic same_w;
    logic yield_w;
    logic buf_take_w;
    logic advance_w;

    // all six requests live at once
    assign req_w = chan_armed_i & rdy_if.ready;

    // scanner position decode
    assign cur_chan_w = SCAN_ORDER[pos_r];
    assign cur_req_w = req_w[cur_chan_w];
    assign pos_inc_w = (pos_r == CHAN_LAST) ? POS_FIRST : pos_r + POS_STEP;

    assign same_w = last_valid_r && (cur_chan_w == last_chan_r);
    assign yield_w = prog_req_i && same_w;

    assign buf_take_w = slot_tick_r && (state_r == BCS_ST_HALT) && cur_req_w && !yield_w;

    // ------------------------------------------------------------
    // slot timing
    // ------------------------------------------------------------

    always_comb begin
        slot_cnt_nxt = slot_cnt_r;
        slot_tick_nxt = 1'b0;
        if (scan_tick_w) begin
            slot_tick_nxt = (slot_cnt_r == CHAN_LAST);
            slot_cnt_nxt = slot_tick_nxt ? POS_FIRST : slot_cnt_r + POS_STEP;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            slot_cnt_r <= '0;
            slot_tick_r <= 1'b0;
        end else begin
            slot_cnt_r <= slot_cnt_nxt;
            slot_tick_r <= slot_tick_nxt;
        end
    end

    // ------------------------------------------------------------
    // scanner
    // ------------------------------------------------------------

    // next scanner state, grants and position
    always_comb begin
        state_nxt = state_r;
        pos_nxt = pos_r;
        last_chan_nxt = last_chan_r;
        last_valid_nxt = last_valid_r;
        buf_grant_nxt = '0;
        buf_chan_nxt = buf_chan_r;
        advance_w = 1'b0;
        case (state_r)
            BCS_ST_SCAN: begin
                if (scan_tick_w) begin
                    if (cur_req_w) begin
                        state_nxt = BCS_ST_HALT;
                    end else begin
                        pos_nxt = pos_inc_w;
                        advance_w = 1'b1;
                    end
                end
            end
            BCS_ST_HALT: begin
                if (!cur_req_w) begin
                    state_nxt = BCS_ST_SCAN;
                end else if (buf_take_w) begin
                    buf_grant_nxt = chan_onehot(cur_chan_w);
                    buf_chan_nxt = cur_chan_w;
                    last_chan_nxt = cur_chan_w;
                    last_valid_nxt = 1'b1;
                    pos_nxt = pos_inc_w;
                    advance_w = 1'b1;
                    state_nxt = BCS_ST_SCAN;
                end else if (slot_tick_r && yield_w) begin
                    // yield only once, next slot is ours
                    last_valid_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = BCS_ST_SCAN;
            end
        endcase
    end

    always_comb begin
        prog_grant_nxt = slot_tick_r && prog_req_i && !buf_take_w;
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= BCS_ST_SCAN;
            pos_r <= '0;
            last_chan_r <= '0;
            last_valid_r <= 1'b0;
            buf_grant_r <= '0;
            buf_chan_r <= '0;
            prog_grant_r <= 1'b0;
            scan_chan_r <= '0;
        end else begin
            state_r <= state_nxt;
            pos_r <= pos_nxt;
            last_chan_r <= last_chan_nxt;
            last_valid_r <= last_valid_nxt;
            buf_grant_r <= buf_grant_nxt;
            buf_chan_r <= buf_chan_nxt;
            prog_grant_r <= prog_grant_nxt;
            scan_chan_r <= SCAN_ORDER[pos_nxt];
        end
    end

    // outputs
    assign buf_grant_o = buf_grant_r;
    assign buf_chan_o = buf_chan_r;
    assign prog_grant_o = prog_grant_r;
    assign slot_o = slot_tick_r;
    assign scan_chan_o = scan_chan_r;
    assign halted_o = (state_r == BCS_ST_HALT);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    localparam logic [10:0] SLOT_GAP = 11'(SLOT_CYCLES - 1);
    localparam bcs_chan_t STEPS_MAX = 3'h7;
    logic [10:0] gap_r;
    logic seen_r;
    bcs_chan_t steps_r;

    // slot spacing and scan steps since the last word
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gap_r <= '0;
            seen_r <= 1'b0;
            steps_r <= '0;
        end else begin
            gap_r <= slot_tick_r ? '0 : gap_r + 11'h1;
            seen_r <= seen_r | slot_tick_r;
            if (buf_take_w) begin
                steps_r <= '0;
            end else if (advance_w && steps_r != STEPS_MAX) begin
                steps_r <= steps_r + POS_STEP;
            end
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);

    chk_one_word: assert property (
        buf_grant_o != '0 |-> $onehot(buf_grant_o) &&
            buf_grant_o == chan_onehot(buf_chan_o) ##1 buf_grant_o == '0)
        else $error("buffer grant not a single word");

    chk_scan_order: assert property (
        scan_tick_w && state_r == BCS_ST_SCAN && !cur_req_w |=>
            pos_r == $past(pos_inc_w) && scan_chan_o == SCAN_ORDER[pos_r])
        else $error("scanner left the fixed order");

    chk_halt_on_req: assert property (
        scan_tick_w && state_r == BCS_ST_SCAN && cur_req_w |=> state_r == BCS_ST_HALT)
        else $error("scanner did not halt on a request");

    chk_visit_others: assert property (
        buf_take_w && same_w |-> steps_r == CHAN_LAST)
        else $error("channel served again before a full pass");

    chk_req_gated: assert property (
        buf_grant_nxt != '0 |-> (buf_grant_nxt & chan_armed_i & rdy_if.ready) != '0)
        else $error("grant given without a request");

    chk_prog_free: assert property (
        slot_tick_r && prog_req_i && state_r == BCS_ST_SCAN |=> prog_grant_o)
        else $error("free slot not given to program");

    chk_buf_first: assert property (
        buf_take_w |=> buf_grant_o != '0 && !prog_grant_o)
        else $error("program beat a buffer word");

    chk_lone_share: assert property (
        slot_tick_r && state_r == BCS_ST_HALT && cur_req_w && prog_req_i && same_w
            |=> prog_grant_o && buf_grant_o == '0)
        else $error("lone channel did not yield a slot");

    chk_slot_rate: assert property (
        slot_tick_r && seen_r |-> gap_r == SLOT_GAP)
        else $error("storage slot spacing wrong");

    chk_idle_cycle: assert property (
        req_w == '0 && scan_tick_w |=> state_r == BCS_ST_SCAN && pos_r == $past(pos_inc_w))
        else $error("scanner stopped with no request");

    cov_buf_word: cover property (buf_grant_o != '0 ##1 buf_grant_o == '0);
    cov_prog_slot: cover property (prog_grant_o);
    cov_yield: cover property (slot_tick_r && yield_w && state_r == BCS_ST_HALT);
    cov_all_armed: cover property (req_w == '1 ##1 buf_grant_o != '0);

endmodule

`default_nettype wire

/* verif/bcs_equip_model.sv */
// Purpose: behavioural model of the peripheral equipment on six buffer channels
// Assumes: one word moves per grant pulse; ready is a level on each channel
// Notes:   slow_i stretches the recovery so equipment can limit the word rate

`timescale 1ns/100ps
`default_nettype none

module bcs_equip_model (
    input wire logic clock_i,              // system clock
    input wire logic sys_rst_i,            // async reset, active high
    input wire bcs_pkg::bcs_vec_t present_i, // equipment has a word to move
    input wire bcs_pkg::bcs_vec_t slow_i,  // slow recovery per channel
    input wire bcs_pkg::bcs_vec_t grant_i, // word taken by the scanner
    output bcs_pkg::bcs_vec_t ready_o      // ready level per channel
);
    import bcs_pkg::*;

    int wait_cnt [CHAN_N];

    // ------------------------------------------------------------
    // per channel ready handshake
    // ------------------------------------------------------------
    // ready only with word
    always @(posedge clock_i or posedge sys_rst_i) begin
        for (int i = 0; i < CHAN_N; i++) begin
            if (sys_rst_i) begin
                ready_o[i] <= 1'b0;
                wait_cnt[i] <= 0;
            end else if (grant_i[i]) begin
                ready_o[i] <= 1'b0;
                wait_cnt[i] <= slow_i[i] ? 3000 : 8;
            end else if (wait_cnt[i] != 0) begin
                wait_cnt[i] <= wait_cnt[i] - 1;
            end else begin
                ready_o[i] <= present_i[i];
            end
        end
    end
endmodule

`default_nettype wire

/* verif/buffer_channel_scanner_test.sv */
// Purpose: self-checking bench of the buffer channel scanner
// Assumes: equipment model answers promptly unless told to be slow
// Notes:   grants are logged with their cycle number by a monitor

`timescale 1ns/100ps
`default_nettype none

module buffer_channel_scanner_test;
    import bcs_pkg::*;

    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    bcs_vec_t armed = 6'h00;
    bcs_vec_t present = 6'h00;
    bcs_vec_t slow = 6'h00;
    logic prog_req = 1'b0;
    bcs_vec_t ready;
    bcs_vec_t grant;
    bcs_chan_t buf_chan;
    bcs_chan_t scan_chan;
    logic prog_grant;
    logic slot;
    logic halted;
    logic slot_q = 1'b0;
    logic halt_q = 1'b0;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int pgc = 0;
    bcs_chan_t gch [$];
    int gtm [$];

    // ------------------------------------------------------------
    // clock, design and equipment
    // ------------------------------------------------------------
    always #(CLK_NS / 2) clock_i = ~clock_i;

    bcs_scanner u_bcs_scanner (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .chan_armed_i(armed),
        .chan_ready_i(ready), .prog_req_i(prog_req), .buf_grant_o(grant), .buf_chan_o(buf_chan),
        .prog_grant_o(prog_grant), .slot_o(slot), .scan_chan_o(scan_chan), .halted_o(halted));

    bcs_equip_model u_bcs_equip_model (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .present_i(present), .slow_i(slow), .grant_i(grant), .ready_o(ready));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic int nxt_of(input bcs_chan_t c);
        int p;
        p = 0;
        for (int i = 0; i < CHAN_N; i++) begin
            if (SCAN_ORDER[i] === c) begin
                p = i;
            end
        end
        return SCAN_ORDER[(p + 1) % CHAN_N];
    endfunction

    task automatic wait_grants(input int n, input int bound);
        int k;
        for (k = 0; k < bound && gch.size() < n; k++) begin
            @(negedge clock_i);
        end
        if (gch.size() < n) begin
            num_errors++;
            $display("[ERR] grant count expected %0d seen %0d", n, gch.size());
            results();
        end
    endtask

    // log every word grant and program slot
    always @(posedge clock_i) begin
        cyc = cyc + 1;
        if (prog_grant === 1'b1) begin
            pgc++;
        end
        if (sys_rst_i === 1'b0 && grant !== 6'h00) begin
            chk("grant_onehot", 6'h01 << buf_chan, grant);
            chk("grant_armed", 1'b1, armed[buf_chan]);
            chk("grant_slot", 1'b1, slot_q);
            chk("grant_halted", 1'b1, halt_q);
            gch.push_back(buf_chan);
            gtm.push_back(cyc);
        end
        slot_q = slot;
        halt_q = halted;
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        repeat (16) @(negedge clock_i);
        sys_rst_i = 1'b0;
        @(negedge clock_i);
        chk("grant_rst", 6'h00, grant);
        chk("prog_rst", 1'b0, prog_grant);
        chk("scan_rst", 3'h0, scan_chan);
        chk("slot_rst", 1'b0, slot);
        chk("halt_rst", 1'b0, halted);
        $display("test reset done");
    endtask

    task automatic t_idle();
        bcs_chan_t seq [7];
        bcs_chan_t prev;
        int n;
        armed = 6'h03;
        present = 6'h3C;
        prog_req = 1'b1;
        prev = scan_chan;
        n = 0;
        for (int k = 0; k < 3000 && n < 7; k++) begin
            @(negedge clock_i);
            if (scan_chan !== prev) begin
                seq[n] = scan_chan;
                n++;
                prev = scan_chan;
            end
        end
        chk("scan_steps", 7, n);
        for (int i = 0; i < 6; i++) begin
            chk("scan_order", nxt_of(seq[i]), seq[i + 1]);
        end
        pgc = 0;
        repeat (2 * SLOT_CYCLES) @(negedge clock_i);
        chk("idle_grants", 0, gch.size());
        chk("idle_prog", 1'b1, pgc >= 2);
        $display("test idle done");
    endtask

    task automatic t_single();
        armed = 6'h08;
        present = 6'h08;
        gch.delete();
        gtm.delete();
        wait_grants(1, 4 * SLOT_CYCLES);
        pgc = 0;
        wait_grants(3, 5 * SLOT_CYCLES);
        chk("single_chan", 3'h3, gch[2]);
        chk("single_gap", 2 * SLOT_CYCLES, gtm[1] - gtm[0]);
        chk("single_prog", 2, pgc);
        chk("rate_worst", 1'b1, gtm[2] - gtm[1] <= 3650);
        prog_req = 1'b0;
        gch.delete();
        gtm.delete();
        wait_grants(2, 3 * SLOT_CYCLES);
        chk("rate_best", 1'b1, gtm[1] - gtm[0] <= 2155);
        $display("test single done");
    endtask

    task automatic t_six();
        armed = 6'h3F;
        present = 6'h3F;
        prog_req = 1'b1;
        gch.delete();
        gtm.delete();
        wait_grants(1, 3 * SLOT_CYCLES);
        pgc = 0;
        wait_grants(13, 14 * SLOT_CYCLES);
        for (int i = 1; i < 12; i++) begin
            chk("six_next", nxt_of(gch[i]), gch[i + 1]);
        end
        for (int i = 1; i < 7; i++) begin
            chk("six_rate", 1'b1, gtm[i + 6] - gtm[i] <= 11111);
        end
        chk("six_prog", 0, pgc);
        $display("test six done");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        t_reset();
        t_idle();
        t_single();
        t_six();
        results();
    end
endmodule

`default_nettype wire
